// >>> hw/mic_irq_ctrl.sv
// interrupt controller top: avalon slave, flags, priority, vectoring
`timescale 1ns/1ns
`default_nettype none
`include "mic_params.svh"
module mic_irq_ctrl (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // avalon-mm slave
  input  wire logic [3:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  output logic      [31:0]      avs_readdata,
  output logic                  avs_waitrequest,
  // external pins and port direction
  input  wire logic [3:0]       ext_irq_pins,
  input  wire logic [3:0]       pin_dir_input,
  // comparator outputs
  input  wire logic [1:0]       cmp_output_bit,
  // peripheral event pulses
  input  wire logic [3:0]       tmr_p_match,
  input  wire logic [3:0]       tmr_a_match,
  input  wire logic [1:0]       time_base_tick,
  input  wire logic             conv_done,
  input  wire logic             lvd_event,
  input  wire logic             eeprom_event,
  input  wire logic             sim_event,
  input  wire logic             uart_event,
  input  wire logic             i2c_timeout,
  // processor core
  input  wire logic             instr_boundary,
  input  wire mic_pkg::mic_pc_t next_pc,
  input  wire logic             return_from_irq_instr,
  output logic                  pc_load,
  output mic_pkg::mic_pc_t      pc_load_addr,
  output logic                  wakeup,
  output logic                  irq_pending
);
  import mic_pkg::*;

  mic_stack_if stk ();

  mic_pc_stack u_stack (
    .clk (clk),
    .rst (rst),
    .st  (stk.stack)
  );

  // register storage, index 1..8 are flag and enable bytes
  mic_byte_t  edge_select_reg_q;
  mic_byte_t  reg_q [1:8];
  mic_byte_t  reg_d [1:8];
  mic_byte_t  hw_set [1:8];
  mic_byte_t  hw_clr [1:8];
  mic_byte_t  reg_mask [1:8];
  mic_state_t state_q;
  mic_state_t state_d;
  logic       ack_q;
  logic       pc_load_q;
  mic_pc_t    pc_load_addr_q;
  logic       wakeup_q;
  logic       pend_q;
  logic [31:0] rdata_q;

  // synchronisers
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic [3:0] pin_prev_q;
  logic [1:0] cmp_s1_q;
  logic [1:0] cmp_s2_q;
  logic [1:0] cmp_prev_q;

  // decode
  logic        req_any;
  logic        wr_hit;
  logic        rd_hit;
  mic_byte_t   rd_byte;
  logic [3:0]  ext_evt;
  logic [3:0]  ext_en;
  logic [1:0]  cmp_evt;
  logic        mf0_set;
  logic        mf1_set;
  logic        mf2_set;
  logic        mf3_set;
  logic [12:0] src_flag;
  logic [12:0] src_en;
  logic [12:0] src_req;
  logic        req_hit;
  mic_idx_t    take_idx;
  logic [12:0] svc;
  logic        accept;
  logic        do_return_from_irq_instr;
  logic        gie;

  function automatic mic_idx_t first_set(input logic [12:0] v);
    mic_idx_t r;
    r = 4'hF;
    for (int i = `MIC_NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : first_set

  function automatic mic_pc_t vec_addr(input mic_idx_t idx);
    return 13'(`MIC_VEC_BASE + 13'(idx) * `MIC_VEC_STEP);
  endfunction : vec_addr

  function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic prev);
    logic rise;
    logic fall;
    rise = now & ~prev;
    fall = ~now & prev;
    return ((sel == `MIC_EDGE_RISE) & rise) | ((sel == `MIC_EDGE_FALL) & fall) |
           ((sel == `MIC_EDGE_BOTH) & (rise | fall));
  endfunction : edge_hit

  // avalon handshake: one wait cycle per access
  assign req_any         = avs_read | avs_write;
  assign avs_waitrequest = req_any & ~ack_q;
  assign wr_hit          = avs_write & ack_q;
  assign rd_hit          = avs_read & ~ack_q;
  assign avs_readdata    = rdata_q;

  assign reg_mask[1] = `MIC_MASK_INTC0;
  assign reg_mask[2] = `MIC_MASK_INTC1;
  assign reg_mask[3] = `MIC_MASK_INTC2;
  assign reg_mask[4] = `MIC_MASK_INTC3;
  assign reg_mask[5] = `MIC_MASK_MFI0;
  assign reg_mask[6] = `MIC_MASK_MFI1;
  assign reg_mask[7] = `MIC_MASK_TMR1;
  assign reg_mask[8] = `MIC_MASK_TMR23;

  assign gie = reg_q[1][`MIC_BIT_GIE];

  // external pins: enable and input direction gate the pin
  assign ext_en = {reg_q[4][1], reg_q[4][0], reg_q[1][2], reg_q[1][1]};
  for (genvar g = 0; g < 4; g++) begin : g_ext
    assign ext_evt[g] = ext_en[g] & pin_dir_input[g] &
                        edge_hit(edge_select_reg_q[2*g+:2], pin_s2_q[g], pin_prev_q[g]);
  end

  assign cmp_evt = cmp_s2_q ^ cmp_prev_q;

  // grouped sources raise their grouped flag on any contributing event
  assign mf0_set = tmr_p_match[0] | tmr_a_match[0];
  assign mf1_set = lvd_event | eeprom_event | sim_event | uart_event;
  assign mf2_set = tmr_p_match[1] | tmr_a_match[1] | i2c_timeout;
  assign mf3_set = tmr_p_match[2] | tmr_a_match[2] | tmr_p_match[3] | tmr_a_match[3];

  // source order is vector order, index 0 at the lowest address
  assign src_flag = {reg_q[4][5], reg_q[4][4], reg_q[3][7], reg_q[3][6], reg_q[3][5],
                     reg_q[3][4], reg_q[2][7], reg_q[2][6], reg_q[2][5], reg_q[1][6],
                     reg_q[2][4], reg_q[1][5], reg_q[1][4]};
  assign src_en   = {reg_q[4][1], reg_q[4][0], reg_q[3][3], reg_q[3][2], reg_q[3][1],
                     reg_q[3][0], reg_q[2][3], reg_q[2][2], reg_q[2][1], reg_q[1][3],
                     reg_q[2][0], reg_q[1][2], reg_q[1][1]};
  assign src_req  = src_flag & src_en;
  assign req_hit  = |src_req;
  assign take_idx = first_set(src_req);

  assign do_return_from_irq_instr = return_from_irq_instr & (state_q == MIC_ST_RUN) & ~stk.empty;
  assign accept  = instr_boundary & gie & req_hit & ~stk.full &
                   (state_q == MIC_ST_RUN) & ~return_from_irq_instr;
  assign svc     = accept ? 13'(13'h0001 << take_idx) : 13'h0000;

  // hardware sets, placed at flag positions
  assign hw_set[1] = {1'b0, mf0_set, ext_evt[1], ext_evt[0], 4'h0};
  assign hw_set[2] = {mf1_set, time_base_tick[1], time_base_tick[0], conv_done, 4'h0};
  assign hw_set[3] = {cmp_evt[1], cmp_evt[0], mf3_set, mf2_set, 4'h0};
  assign hw_set[4] = {2'h0, ext_evt[3], ext_evt[2], 4'h0};
  assign hw_set[5] = {2'h0, tmr_a_match[0], tmr_p_match[0], 4'h0};
  assign hw_set[6] = {uart_event, sim_event, eeprom_event, lvd_event, 4'h0};
  assign hw_set[7] = {i2c_timeout, 1'b0, tmr_a_match[1], tmr_p_match[1], 4'h0};
  assign hw_set[8] = {tmr_a_match[3], tmr_p_match[3], tmr_a_match[2], tmr_p_match[2], 4'h0};

  // service clears the taken flag and the global enable only
  assign hw_clr[1] = {1'b0, svc[3], svc[1], svc[0], 3'h0, accept};
  assign hw_clr[2] = {svc[6], svc[5], svc[4], svc[2], 4'h0};
  assign hw_clr[3] = {svc[10], svc[9], svc[8], svc[7], 4'h0};
  assign hw_clr[4] = {2'h0, svc[12], svc[11], 4'h0};
  assign hw_clr[5] = 8'h00;
  assign hw_clr[6] = 8'h00;
  assign hw_clr[7] = 8'h00;
  assign hw_clr[8] = 8'h00;

  // set wins over a software or service clear
  for (genvar r = 1; r <= 8; r++) begin : g_reg
    assign reg_d[r] = (((wr_hit && avs_address == 4'(r)) ? avs_writedata[7:0] : reg_q[r]) &
                       ~hw_clr[r] | hw_set[r]) & reg_mask[r];
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        reg_q[r] <= `MIC_RST_REG;
      end else begin
        reg_q[r] <= reg_d[r];
      end
    end
  end

  // read mux
  assign rd_byte = (avs_address == `MIC_IDX_EDGE_SEL) ? edge_select_reg_q :
                   (avs_address == `MIC_IDX_STATUS) ?
                     {2'h0, req_hit, stk.full, stk.level} :
                   (avs_address >= `MIC_IDX_INTC0 && avs_address <= `MIC_IDX_TMR23) ?
                     reg_q[avs_address] : 8'h00;

  // stack traffic
  assign stk.push    = accept;
  assign stk.push_pc = next_pc;
  assign stk.pop     = do_return_from_irq_instr;

  always_comb begin
    state_d = state_q;
    case (state_q)
      MIC_ST_RUN: begin
        if (accept || do_return_from_irq_instr) begin
          state_d = MIC_ST_LOAD;
        end
      end
      MIC_ST_LOAD: begin
        state_d = MIC_ST_RUN;
      end
      default: begin
        state_d = MIC_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= MIC_ST_RUN;
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      ack_q   <= req_any & ~ack_q;
      if (rd_hit) begin
        rdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      edge_select_reg_q <= `MIC_RST_EDGE_SEL;
    end else if (wr_hit && avs_address == `MIC_IDX_EDGE_SEL) begin
      edge_select_reg_q <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_load_q      <= 1'b0;
      pc_load_addr_q <= 13'h0000;
    end else begin
      pc_load_q <= accept | do_return_from_irq_instr;
      if (accept) begin
        pc_load_addr_q <= vec_addr(take_idx);
      end else if (do_return_from_irq_instr) begin
        pc_load_addr_q <= stk.top_pc;
      end
    end
  end

  // wake-up pulse on any newly set flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wakeup_q <= 1'b0;
      pend_q   <= 1'b0;
    end else begin
      wakeup_q <= |((reg_d[1] & ~reg_q[1]) & 8'h70) | |((reg_d[2] & ~reg_q[2]) & 8'hF0) |
                  |((reg_d[3] & ~reg_q[3]) & 8'hF0) | |((reg_d[4] & ~reg_q[4]) & 8'h30) |
                  |((reg_d[5] & ~reg_q[5]) & 8'h30) | |((reg_d[6] & ~reg_q[6]) & 8'hF0) |
                  |((reg_d[7] & ~reg_q[7]) & 8'hB0) | |((reg_d[8] & ~reg_q[8]) & 8'hF0);
      pend_q   <= req_hit;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1_q   <= 4'h0;
      pin_s2_q   <= 4'h0;
      pin_prev_q <= 4'h0;
      cmp_s1_q   <= 2'h0;
      cmp_s2_q   <= 2'h0;
      cmp_prev_q <= 2'h0;
    end else begin
      pin_s1_q   <= ext_irq_pins;
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
      cmp_s1_q   <= cmp_output_bit;
      cmp_s2_q   <= cmp_s1_q;
      cmp_prev_q <= cmp_s2_q;
    end
  end

  assign pc_load      = pc_load_q;
  assign pc_load_addr = pc_load_addr_q;
  assign wakeup       = wakeup_q;
  assign irq_pending  = pend_q;

  a_take_clears_gie: assert property (@(posedge clk) disable iff (rst)
    accept |=> !gie || $past(hw_set[1][0]))
    else $error("global enable not cleared on service");

  a_take_needs_gie: assert property (@(posedge clk) disable iff (rst)
    !gie |-> !accept)
    else $error("interrupt taken with global enable clear");

  a_full_blocks: assert property (@(posedge clk) disable iff (rst)
    stk.full |-> !accept)
    else $error("interrupt taken with stack full");

  a_disabled_no_take: assert property (@(posedge clk) disable iff (rst)
    accept |-> src_en[take_idx] && src_flag[take_idx])
    else $error("disabled source vectored");

  a_lowest_wins: assert property (@(posedge clk) disable iff (rst)
    accept |-> (src_req & ((13'h0001 << take_idx) - 13'h0001)) == 13'h0000)
    else $error("lower vector not preferred");

  a_vector_load: assert property (@(posedge clk) disable iff (rst)
    accept |=> pc_load && pc_load_addr == 13'(`MIC_VEC_BASE + 13'($past(take_idx)) * 4)
           ##1 !pc_load)
    else $error("wrong vector loaded");

  a_return_from_irq_instr_restores: assert property (@(posedge clk) disable iff (rst)
    do_return_from_irq_instr |=> pc_load && pc_load_addr == $past(stk.top_pc) && stk.level == $past(stk.level) - 1)
    else $error("return address not restored");

  a_group_keeps_subs: assert property (@(posedge clk) disable iff (rst)
    accept && !wr_hit |=> (reg_q[6] & 8'hF0) == ($past(reg_q[6]) & 8'hF0 | $past(hw_set[6])))
    else $error("grouped source flags changed by service");

  a_cmp_change_sets: assert property (@(posedge clk) disable iff (rst)
    $changed(cmp_s2_q[0]) && !wr_hit |-> ##1 reg_q[3][6])
    else $error("comparator change lost");

  a_wake_on_flag: assert property (@(posedge clk) disable iff (rst)
    conv_done && !reg_q[2][4] |=> wakeup)
    else $error("no wake-up on new flag");
endmodule : mic_irq_ctrl
`default_nettype wire

// >>> hw/mic_params.svh
// constants of the interrupt controller: offsets, layouts, reset values, vectors
`ifndef MIC_PARAMS_SVH
`define MIC_PARAMS_SVH

// register word indexes on the avalon slave
`define MIC_IDX_EDGE_SEL   4'h0
`define MIC_IDX_INTC0      4'h1
`define MIC_IDX_INTC1      4'h2
`define MIC_IDX_INTC2      4'h3
`define MIC_IDX_INTC3      4'h4
`define MIC_IDX_MFI0       4'h5
`define MIC_IDX_MFI1       4'h6
`define MIC_IDX_TMR1       4'h7
`define MIC_IDX_TMR23      4'h8
`define MIC_IDX_STATUS     4'h9

// implemented bits of each flag and enable register
`define MIC_MASK_INTC0     8'h7F
`define MIC_MASK_INTC1     8'hFF
`define MIC_MASK_INTC2     8'hFF
`define MIC_MASK_INTC3     8'h33
`define MIC_MASK_MFI0      8'h33
`define MIC_MASK_MFI1      8'hFF
`define MIC_MASK_TMR1      8'hBB
`define MIC_MASK_TMR23     8'hFF

// reset values
`define MIC_RST_REG        8'h00
`define MIC_RST_EDGE_SEL   8'h00

// field positions
`define MIC_BIT_GIE        0
`define MIC_STAT_FULL      4
`define MIC_STAT_PEND      5

// edge select codes
`define MIC_EDGE_OFF       2'h0
`define MIC_EDGE_RISE      2'h1
`define MIC_EDGE_FALL      2'h2
`define MIC_EDGE_BOTH      2'h3

// vectors and stack
`define MIC_NUM_SRC        13
`define MIC_VEC_BASE       13'h0004
`define MIC_VEC_STEP       13'h0004
`define MIC_STACK_DEPTH    4'h8

`endif

// >>> hw/mic_pkg.sv
// types of the interrupt controller
package mic_pkg;
  typedef logic [12:0] mic_pc_t;
  typedef logic [3:0]  mic_idx_t;
  typedef logic [7:0]  mic_byte_t;
  typedef logic [3:0]  mic_level_t;
  typedef enum logic [1:0] {
    MIC_ST_RUN  = 2'b00,
    MIC_ST_LOAD = 2'b01
  } mic_state_t;
endpackage : mic_pkg

// >>> hw/mic_stack_if.sv
// carrier between the controller and its return address stack
`timescale 1ns/1ns
`default_nettype none
interface mic_stack_if;
  import mic_pkg::*;
  logic       push;
  logic       pop;
  mic_pc_t    push_pc;
  mic_pc_t    top_pc;
  mic_level_t level;
  logic       full;
  logic       empty;
  modport ctrl  (output push, output pop, output push_pc,
                 input top_pc, input level, input full, input empty);
  modport stack (input push, input pop, input push_pc,
                 output top_pc, output level, output full, output empty);
endinterface : mic_stack_if
`default_nettype wire

// >>> hw/mic_pc_stack.sv
// return address stack of the interrupt controller
`timescale 1ns/1ns
`default_nettype none
`include "mic_params.svh"
module mic_pc_stack (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rst,
  // controller side
  mic_stack_if.stack st
);
  import mic_pkg::*;

  mic_pc_t    mem_q [0:7];
  mic_level_t sp_q;
  logic       do_push;
  logic       do_pop;
  logic [2:0] top_idx;

  assign st.level = sp_q;
  assign st.full  = (sp_q == `MIC_STACK_DEPTH);
  assign st.empty = (sp_q == 4'h0);
  assign do_push  = st.push & ~st.full;
  assign do_pop   = st.pop & ~st.empty & ~st.push;
  assign top_idx  = 3'(sp_q - 4'h1);
  assign st.top_pc = st.empty ? 13'h0000 : mem_q[top_idx];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sp_q <= 4'h0;
    end else if (do_push) begin
      sp_q <= 4'(sp_q + 4'h1);
    end else if (do_pop) begin
      sp_q <= 4'(sp_q - 4'h1);
    end
  end

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_q[sp_q[2:0]] <= st.push_pc;
    end
  end
endmodule : mic_pc_stack
`default_nettype wire

// >>> sim/mic_core_model.sv
// core side model: program counter, vector loads and returns
`timescale 1ns/1ns
`default_nettype none
module mic_core_model #(
  parameter mic_pkg::mic_pc_t START_PC = 13'h0123
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // bench commands
  input  wire logic             boundary_en,
  input  wire logic             ret_cmd,
  // controller side
  input  wire logic             pc_load,
  input  wire mic_pkg::mic_pc_t pc_load_addr,
  output logic                  instr_boundary,
  output mic_pkg::mic_pc_t      next_pc,
  output logic                  return_from_irq_instr
);
  import mic_pkg::*;
  mic_pc_t pc_q;
  logic    ret_q;
  assign next_pc = pc_q;
  assign return_from_irq_instr = ret_q;
  // no boundary while a return executes
  assign instr_boundary = boundary_en & ~ret_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_q  <= START_PC;
      ret_q <= 1'b0;
    end else begin
      ret_q <= ret_cmd & ~pc_load;
      if (pc_load) begin
        pc_q <= pc_load_addr;
      end
    end
  end
endmodule : mic_core_model
`default_nettype wire

// >>> sim/mic_irq_ctrl_tb_top.sv
// self-checking bench of the interrupt controller
`timescale 1ns/1ns
`default_nettype none
`include "mic_params.svh"
module mic_irq_ctrl_tb_top;
  import mic_pkg::*;
  logic        clk, rst, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address, ext_irq_pins, pin_dir_input, tmr_p_match, tmr_a_match;
  logic [31:0] avs_writedata, avs_readdata;
  logic [1:0]  cmp_output_bit, time_base_tick;
  logic        conv_done, lvd_event, eeprom_event, sim_event, uart_event, i2c_timeout;
  logic        instr_boundary, return_from_irq_instr, pc_load, wakeup, irq_pending;
  logic        boundary_en, ret_cmd;
  mic_pc_t     next_pc, pc_load_addr;
  int          mismatches, n_checks, wake_cnt;

  mic_irq_ctrl dut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .ext_irq_pins, .pin_dir_input, .cmp_output_bit,
    .tmr_p_match, .tmr_a_match, .time_base_tick, .conv_done, .lvd_event, .eeprom_event,
    .sim_event, .uart_event, .i2c_timeout, .instr_boundary, .next_pc,
    .return_from_irq_instr, .pc_load, .pc_load_addr, .wakeup, .irq_pending);
  mic_core_model core (.clk, .rst, .boundary_en, .ret_cmd, .pc_load, .pc_load_addr,
    .instr_boundary, .next_pc, .return_from_irq_instr);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (wakeup === 1'b1) wake_cnt <= wake_cnt + 1;
  end

  task automatic chk8(input string nm, input mic_byte_t exp, input mic_byte_t got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk8

  task automatic chk_pc(input string nm, input mic_pc_t exp, input mic_pc_t got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_pc

  task automatic chk_bit(input string nm, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk_bit

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input mic_idx_t a, input mic_byte_t d,
                     output mic_byte_t q);
    int n;
    n = 0;
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= ~w;
    avs_writedata <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    chk_bit("waitrequest", 1'b0, avs_waitrequest);
    q = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input mic_idx_t a, input mic_byte_t d);
    mic_byte_t q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input string nm, input mic_idx_t a, input mic_byte_t exp);
    mic_byte_t q;
    bus(1'b0, a, 8'h00, q);
    chk8(nm, exp, q);
  endtask : rdc

  // one-cycle events: conv, lvd, uart, eeprom, timer0 p match
  task automatic pulse(input logic [4:0] m);
    {conv_done, lvd_event, uart_event, eeprom_event, tmr_p_match[0]} <= m;
    @(posedge clk);
    {conv_done, lvd_event, uart_event, eeprom_event, tmr_p_match[0]} <= 5'h00;
    @(posedge clk);
  endtask : pulse

  task automatic wait_load(input logic exp, input mic_pc_t addr);
    int n;
    n = 0;
    while (pc_load !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk_bit("pc_load", exp, pc_load);
    if (exp) chk_pc("pc_load_addr", addr, pc_load_addr);
    @(posedge clk);
  endtask : wait_load

  task automatic ret_to(input mic_pc_t addr);
    ret_cmd <= 1'b1;
    @(posedge clk);
    ret_cmd <= 1'b0;
    wait_load(1'b1, addr);
  endtask : ret_to

  task automatic t_regs();
    mic_byte_t m [9];
    m = '{8'hFF, `MIC_MASK_INTC0, `MIC_MASK_INTC1, `MIC_MASK_INTC2, `MIC_MASK_INTC3,
          `MIC_MASK_MFI0, `MIC_MASK_MFI1, `MIC_MASK_TMR1, `MIC_MASK_TMR23};
    boundary_en <= 1'b0;
    for (int i = 0; i < 9; i++) rdc("reset value", i[3:0], 8'h00);
    for (int i = 0; i < 9; i++) begin
      wr(i[3:0], 8'hFF);
      rdc("bit mask", i[3:0], m[i]);
      wr(i[3:0], 8'h00);
    end
    wr(`MIC_IDX_STATUS, 8'hFF);
    rdc("status", `MIC_IDX_STATUS, 8'h00);
    wr(4'hA, 8'hFF);
    rdc("unmapped", 4'hA, 8'h00);
    boundary_en <= 1'b1;
  endtask : t_regs

  task automatic t_prio();
    wr(`MIC_IDX_INTC0, 8'h01);
    pulse(5'h1E);
    wait_load(1'b0, 13'h0000);
    rdc("intc1 flags", `MIC_IDX_INTC1, 8'h90);
    rdc("mfi1 flags", `MIC_IDX_MFI1, 8'hB0);
    wr(`MIC_IDX_INTC0, 8'h00);
    wr(`MIC_IDX_INTC1, 8'h99);
    wait_load(1'b0, 13'h0000);
    wr(`MIC_IDX_INTC0, 8'h01);
    wait_load(1'b1, 13'h000C);
    rdc("adc served", `MIC_IDX_INTC1, 8'h89);
    rdc("global off", `MIC_IDX_INTC0, 8'h00);
    wr(`MIC_IDX_INTC0, 8'h01);
    wait_load(1'b1, 13'h001C);
    rdc("group served", `MIC_IDX_INTC1, 8'h09);
    rdc("sources kept", `MIC_IDX_MFI1, 8'hB0);
    ret_to(13'h000C);
    ret_to(13'h0123);
    wr(`MIC_IDX_INTC1, 8'h00);
  endtask : t_prio

  task automatic t_stack();
    for (int i = 0; i < 8; i++) begin
      wr(`MIC_IDX_INTC0, 8'h09);
      pulse(5'h01);
      wait_load(1'b1, 13'h0010);
    end
    wr(`MIC_IDX_INTC0, 8'h09);
    pulse(5'h01);
    wait_load(1'b0, 13'h0000);
    rdc("stack status", `MIC_IDX_STATUS, 8'h38);
    ret_to(13'h0010);
    wait_load(1'b1, 13'h0010);
    for (int i = 0; i < 7; i++) ret_to(13'h0010);
    ret_to(13'h0123);
    wr(`MIC_IDX_INTC0, 8'h00);
  endtask : t_stack

  task automatic t_ext();
    int w0;
    wr(`MIC_IDX_INTC0, 8'h02);
    pin_dir_input <= 4'h1;
    for (int c = 0; c < 4; c++) begin
      wr(`MIC_IDX_EDGE_SEL, c[7:0]);
      w0 = wake_cnt;
      ext_irq_pins <= 4'h1;
      repeat (6) @(posedge clk);
      rdc("rise flag", `MIC_IDX_INTC0, {3'h0, c[0], 4'h2});
      chk_bit("wakeup", c[0], wake_cnt > w0);
      wr(`MIC_IDX_INTC0, 8'h02);
      ext_irq_pins <= 4'h0;
      repeat (6) @(posedge clk);
      rdc("fall flag", `MIC_IDX_INTC0, {3'h0, c[1], 4'h2});
      wr(`MIC_IDX_INTC0, 8'h02);
    end
    pin_dir_input <= 4'h0;
    ext_irq_pins  <= 4'h1;
    repeat (6) @(posedge clk);
    rdc("output pin", `MIC_IDX_INTC0, 8'h02);
    wr(`MIC_IDX_EDGE_SEL, 8'h01);
    pin_dir_input <= 4'h1;
    ext_irq_pins  <= 4'h0;
    wr(`MIC_IDX_INTC0, 8'h03);
    ext_irq_pins <= 4'h1;
    wait_load(1'b1, 13'h0004);
    rdc("pin served", `MIC_IDX_INTC0, 8'h02);
    ret_to(13'h0123);
    wr(`MIC_IDX_INTC0, 8'h00);
  endtask : t_ext

  task automatic t_cmp();
    wr(`MIC_IDX_INTC2, 8'h04);
    wr(`MIC_IDX_INTC0, 8'h01);
    cmp_output_bit <= 2'h1;
    wait_load(1'b1, 13'h0028);
    rdc("cmp served", `MIC_IDX_INTC2, 8'h04);
    ret_to(13'h0123);
    cmp_output_bit <= 2'h3;
    repeat (6) @(posedge clk);
    rdc("cmp1 flag", `MIC_IDX_INTC2, 8'h84);
  endtask : t_cmp

  // remaining sources: time base, timers 1..3, serial, bus time-out
  task automatic t_groups();
    wr(`MIC_IDX_INTC2, 8'h00);
    tmr_p_match    <= 4'hE;
    tmr_a_match    <= 4'hE;
    time_base_tick <= 2'h3;
    sim_event      <= 1'b1;
    i2c_timeout    <= 1'b1;
    @(posedge clk);
    tmr_p_match    <= 4'h0;
    tmr_a_match    <= 4'h0;
    time_base_tick <= 2'h0;
    sim_event      <= 1'b0;
    i2c_timeout    <= 1'b0;
    @(posedge clk);
    rdc("tb and mf1 flags", `MIC_IDX_INTC1, 8'hE0);
    rdc("mf2 mf3 flags", `MIC_IDX_INTC2, 8'h30);
    rdc("mfi1 sim flag", `MIC_IDX_MFI1, 8'hF0);
    rdc("timer1 flags", `MIC_IDX_TMR1, 8'hB0);
    rdc("timer23 flags", `MIC_IDX_TMR23, 8'hF0);
    wr(`MIC_IDX_INTC2, 8'h33);
    wr(`MIC_IDX_INTC0, 8'h01);
    wait_load(1'b1, 13'h0020);
    rdc("mf2 served", `MIC_IDX_INTC2, 8'h23);
    ret_to(13'h0123);
    chk_bit("irq_pending", 1'b1, irq_pending);
    wr(`MIC_IDX_INTC2, 8'h00);
    @(posedge clk);
    chk_bit("irq_pending", 1'b0, irq_pending);
  endtask : t_groups

  task automatic summarize();
    if (mismatches == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  initial begin
    {mismatches, n_checks, wake_cnt} = '0;
    {rst, boundary_en} = 2'h3;
    {avs_read, avs_write, ret_cmd, avs_address, avs_writedata} = '0;
    {ext_irq_pins, pin_dir_input, tmr_p_match, tmr_a_match} = 16'h0000;
    {cmp_output_bit, time_base_tick} = 4'h0;
    {conv_done, lvd_event, eeprom_event, sim_event, uart_event, i2c_timeout} = 6'h00;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_prio();
    t_stack();
    t_ext();
    t_cmp();
    t_groups();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize();
  end
endmodule : mic_irq_ctrl_tb_top
`default_nettype wire
